// ---- verilog/pdb_regs.svh ----
`ifndef PDB_REGS_SVH
`define PDB_REGS_SVH
`define PDB_PIXELS      500
`define PDB_LEVEL_W     16
`define PDB_SHORT_MS    5
`define PDB_US_PER_MS   1000
`define PDB_LOG_FRAC    11
`define PDB_FIFO_DEPTH  4
`endif

// ---- verilog/pdb_pkg.sv ----
`default_nettype none
package pdb_pkg;
   typedef enum logic [2:0] {
      PDB_AUTO  = 3'h0,
      PDB_APEAK = 3'h1,
      PDB_MAXP  = 3'h2,
      PDB_MINP  = 3'h3,
      PDB_SAMP  = 3'h4,
      PDB_RMS   = 3'h5,
      PDB_AVG   = 3'h6,
      PDB_SWING = 3'h7
   } pdb_det_t;
   typedef enum logic [1:0] {
      PDB_CLRW = 2'h0,
      PDB_AVGM = 2'h1,
      PDB_MAXH = 2'h2,
      PDB_MINH = 2'h3
   } pdb_mode_t;
   typedef enum logic [1:0] {
      PDB_S_IDLE = 2'h0,
      PDB_S_RUN  = 2'h1,
      PDB_S_DONE = 2'h2
   } pdb_sweep_t;
   typedef struct packed {
      logic        log_display;
      logic        swing_fitted;
      logic        time_domain;
      logic        pretrigger;
      logic        gapped;
      logic [31:0] sweep_time_us;
   } pdb_cfg_t;
   typedef struct packed {
      logic [31:0] hi;
      logic [31:0] lo;
   } pdb_pix_t;
   typedef struct packed {
      logic [8:0]     index;
      pdb_pix_t [3:0] trace;
   } pdb_frame_t;
endpackage
`default_nettype wire

// ---- verilog/pdb_detector_bank.sv ----
// Functional notes
// R1: 500 equal pixel bins, samples merged per bin.
// R2: Max detector outputs largest sample per pixel.
// R3: Min detector outputs smallest sample per pixel.
// R4: Running extreme compared; emitted at configured count.
// R5: Pipelined so no sample skipped between pixels.
// R6: All detectors run in parallel on stream.
// R7: Autopeak outputs max and min together.
// R8: Sample detector never combines; surplus samples dropped.
// R9: Sample mode passes every n-th value.
// R10: Sweep steps are a multiple of 500.
// R11: Rms: mean of squares, log or linear.
// R12: Average: linear mean, log or linear.
// R13: Swing: max minus min, log or linear.
// R14: Swing selectable only with option fitted.
// R15: Separate detector selection per trace.
// R16: One active choice per trace; new replaces old.
// R17: Auto default, maps trace mode to detector.
// R18: Short time-domain sweep: one common detector.
// R19: Rms refused for short, pretrigger or gapped.
// R20: Average has same restrictions as rms.
// R21: Pixel boundary clears extremes, sums and count.
`include "pdb_regs.svh"
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// Output buffer.
// ****************************************
module pdb_fifo #(
   parameter int W = 8,
   parameter int D = `PDB_FIFO_DEPTH
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = (D > 1) ? $clog2(D) : 1;
   logic [W-1:0]      mem [D];
   logic [AW-1:0]     wr_reg;
   logic [AW-1:0]     rd_reg;
   logic [$clog2(D+1)-1:0] cnt_reg;
   logic              push;
   logic              pop;

   assign in_ready  = (cnt_reg != D[$clog2(D+1)-1:0]);
   assign out_valid = (cnt_reg != '0);
   assign out_data  = mem[rd_reg];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_reg] <= in_data;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_reg  <= '0;
         rd_reg  <= '0;
         cnt_reg <= '0;
      end else begin
         if (push) begin
            wr_reg <= (wr_reg == AW'(D - 1)) ? '0 : wr_reg + 1'b1;
         end
         if (pop) begin
            rd_reg <= (rd_reg == AW'(D - 1)) ? '0 : rd_reg + 1'b1;
         end
         cnt_reg <= cnt_reg + push - pop;
      end
   end
endmodule // pdb_fifo

// ****************************************
// Detector bank.
// ****************************************
module pdb_detector_bank (
   input  wire logic                   clk,
   input  wire logic                   rst,
   input  wire logic                   sweep_start,
   input  wire logic [15:0]            samples_per_pixel,
   input  wire pdb_pkg::pdb_cfg_t      cfg,
   input  wire pdb_pkg::pdb_mode_t [3:0] trace_mode,
   input  wire logic [3:0]             sel_write,
   input  wire pdb_pkg::pdb_det_t      sel_value,
   output pdb_pkg::pdb_det_t [3:0]     det_active,
   input  wire logic                   sample_valid,
   output logic                        sample_ready,
   input  wire logic [`PDB_LEVEL_W-1:0] sample_level,
   output logic                        pix_valid,
   input  wire logic                   pix_ready,
   output pdb_pkg::pdb_frame_t         pix_data,
   output logic                        sweep_done
);
   import pdb_pkg::*;

   localparam int LW = `PDB_LEVEL_W;

   // ****************************************
   // Detector choice per trace.
   // ****************************************
   pdb_det_t   sel_reg [4];
   pdb_det_t   eff_reg [4];
   pdb_det_t   res_next [4];
   pdb_det_t   eff_next [4];
   logic       restricted;
   logic       short_td;

   assign short_td   = cfg.time_domain && (cfg.sweep_time_us < 32'(`PDB_SHORT_MS * `PDB_US_PER_MS));
   assign restricted = short_td || (cfg.time_domain && (cfg.pretrigger || cfg.gapped)); // R19 R20

   function automatic pdb_det_t auto_map(input pdb_mode_t m);
      case (m) // R17
         PDB_CLRW: auto_map = PDB_APEAK;
         PDB_AVGM: auto_map = PDB_SAMP;
         PDB_MAXH: auto_map = PDB_MAXP;
         PDB_MINH: auto_map = PDB_MINP;
         default:  auto_map = PDB_APEAK;
      endcase
   endfunction

   function automatic logic refused(input pdb_det_t d, input logic restr, input logic fitted);
      refused = ((d == PDB_SWING) && !fitted) || (((d == PDB_RMS) || (d == PDB_AVG)) && restr);
   endfunction

   genvar t;
   generate
      for (t = 0; t < 4; t++) begin : g_sel
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               sel_reg[t] <= PDB_AUTO; // R17
            end else if (sel_write[t] && !refused(sel_value, restricted, cfg.swing_fitted)) begin // R14 R19 R20
               sel_reg[t] <= sel_value; // R15 R16
            end
         end
         always_comb begin
            if (sel_reg[t] == PDB_AUTO || refused(sel_reg[t], restricted, cfg.swing_fitted)) begin
               res_next[t] = auto_map(trace_mode[t]); // R17
            end else begin
               res_next[t] = sel_reg[t];
            end
         end
         assign eff_next[t] = short_td ? res_next[0] : res_next[t]; // R18
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               eff_reg[t] <= PDB_APEAK;
            end else begin
               eff_reg[t] <= eff_next[t];
            end
         end
         assign det_active[t] = eff_reg[t];
      end
   endgenerate

   // ****************************************
   // Sweep sequencing and accumulation.
   // ****************************************
   pdb_sweep_t     state_reg;
   logic [15:0]    cnt_reg;
   logic [8:0]     idx_reg;
   logic [LW-1:0]  max_reg;
   logic [LW-1:0]  min_reg;
   logic [LW-1:0]  samp_reg;
   logic [31:0]    sum_reg;
   logic [47:0]    sq_reg;
   logic           cap_valid_reg;
   logic [8:0]     cap_idx_reg;
   logic [LW-1:0]  cap_max_reg;
   logic [LW-1:0]  cap_min_reg;
   logic [LW-1:0]  cap_samp_reg;
   logic [31:0]    cap_sum_reg;
   logic [47:0]    cap_sq_reg;
   logic [15:0]    spp;
   logic           take;
   logic           first;
   logic           last;
   logic           fifo_in_ready;
   logic [LW-1:0]  max_next;
   logic [LW-1:0]  min_next;
   logic [LW-1:0]  samp_next;
   logic [31:0]    sum_next;
   logic [47:0]    sq_next;

   assign spp          = (samples_per_pixel == 16'h0000) ? 16'h0001 : samples_per_pixel;
   assign sample_ready = !cap_valid_reg || fifo_in_ready; // R5
   assign take         = sample_valid && sample_ready;
   assign first        = (cnt_reg == 16'h0000);
   assign last         = (cnt_reg == spp - 16'h0001); // R4 R10
   assign sweep_done   = (state_reg == PDB_S_DONE);

   always_comb begin
      max_next  = (first || sample_level > max_reg) ? sample_level : max_reg; // R2 R4 R21
      min_next  = (first || sample_level < min_reg) ? sample_level : min_reg; // R3 R4 R21
      samp_next = first ? sample_level : samp_reg; // R8 R9
      sum_next  = (first ? 32'h0 : sum_reg) + 32'(sample_level); // R12 R21
      sq_next   = (first ? 48'h0 : sq_reg) + (48'(sample_level) * 48'(sample_level)); // R11 R21
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= PDB_S_IDLE;
         cnt_reg   <= '0;
         idx_reg   <= '0;
      end else if (sweep_start) begin
         state_reg <= PDB_S_RUN;
         cnt_reg   <= '0; // R21
         idx_reg   <= '0;
      end else begin
         case (state_reg)
            PDB_S_RUN: begin
               if (take) begin
                  cnt_reg <= last ? 16'h0000 : cnt_reg + 16'h0001; // R21
                  if (last) begin
                     idx_reg <= idx_reg + 9'h001; // R1
                     if (idx_reg == 9'(`PDB_PIXELS - 1)) begin
                        state_reg <= PDB_S_DONE; // R8
                     end
                  end
               end
            end
            PDB_S_IDLE, PDB_S_DONE: begin
               cnt_reg <= cnt_reg;
            end
            default: state_reg <= PDB_S_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         max_reg  <= '0;
         min_reg  <= '0;
         samp_reg <= '0;
         sum_reg  <= '0;
         sq_reg   <= '0;
      end else if (take && state_reg == PDB_S_RUN) begin // R6
         max_reg  <= max_next;
         min_reg  <= min_next;
         samp_reg <= samp_next;
         sum_reg  <= sum_next;
         sq_reg   <= sq_next;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cap_valid_reg <= 1'b0;
         cap_idx_reg   <= '0;
         cap_max_reg   <= '0;
         cap_min_reg   <= '0;
         cap_samp_reg  <= '0;
         cap_sum_reg   <= '0;
         cap_sq_reg    <= '0;
      end else if (take && last && state_reg == PDB_S_RUN && !sweep_start) begin // R4 R5
         cap_valid_reg <= 1'b1;
         cap_idx_reg   <= idx_reg;
         cap_max_reg   <= max_next;
         cap_min_reg   <= min_next;
         cap_samp_reg  <= samp_next;
         cap_sum_reg   <= sum_next;
         cap_sq_reg    <= sq_next;
      end else if (fifo_in_ready) begin
         cap_valid_reg <= 1'b0;
      end
   end

   // ****************************************
   // Result formation.
   // ****************************************
   function automatic logic [31:0] log2fx(input logic [31:0] v);
      logic [4:0]  pos;
      logic [31:0] norm;
      pos  = 5'h00;
      norm = 32'h0;
      for (int b = 0; b < 32; b++) begin
         if (v[b]) begin
            pos = 5'(b);
         end
      end
      norm = v << (5'd31 - pos);
      log2fx = {16'h0000, pos, norm[30 -: `PDB_LOG_FRAC]};
   endfunction

   logic [31:0] mean;
   logic [47:0] msq_full;
   logic [31:0] msq;
   logic [31:0] swing;
   pdb_frame_t  frame;
   pdb_pix_t    pix_res [4];

   assign mean     = cap_sum_reg / 32'(spp); // R12
   assign msq_full = cap_sq_reg / 48'(spp); // R11
   assign msq      = msq_full[31:0];
   assign swing    = 32'(cap_max_reg - cap_min_reg); // R13
   assign frame = {cap_idx_reg, pix_res[3], pix_res[2], pix_res[1], pix_res[0]};

   generate
      for (t = 0; t < 4; t++) begin : g_res
         always_comb begin
            pix_res[t].hi = 32'h0;
            pix_res[t].lo = 32'h0;
            case (eff_reg[t]) // R6
               PDB_APEAK: begin
                  pix_res[t].hi = 32'(cap_max_reg); // R7
                  pix_res[t].lo = 32'(cap_min_reg); // R7
               end
               PDB_MAXP:  pix_res[t].hi = 32'(cap_max_reg); // R2
               PDB_MINP:  pix_res[t].hi = 32'(cap_min_reg); // R3
               PDB_SAMP:  pix_res[t].hi = 32'(cap_samp_reg); // R9
               PDB_RMS:   pix_res[t].hi = cfg.log_display ? log2fx(msq) : msq; // R11
               PDB_AVG:   pix_res[t].hi = cfg.log_display ? log2fx(mean) : mean; // R12
               PDB_SWING: pix_res[t].hi = cfg.log_display ? log2fx(swing) : swing; // R13
               default:   pix_res[t].hi = 32'h0;
            endcase
            if (eff_reg[t] != PDB_APEAK) begin
               pix_res[t].lo = pix_res[t].hi;
            end
         end
      end
   endgenerate

   pdb_fifo #(
      .W ($bits(pdb_frame_t)),
      .D (`PDB_FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .rst       (rst),
      .in_valid  (cap_valid_reg),
      .in_ready  (fifo_in_ready),
      .in_data   (frame),
      .out_valid (pix_valid),
      .out_ready (pix_ready),
      .out_data  (pix_data)
   );

   // ****************************************
   // Checks.
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_idx_range;
      cap_valid_reg |-> cap_idx_reg < 9'(`PDB_PIXELS);
   endproperty
   a_idx_range: assert property (p_idx_range) else $error("pixel index out of range"); // R1

   property p_emit;
      take && last && state_reg == PDB_S_RUN && !sweep_start |=> cap_valid_reg && cnt_reg == 16'h0000;
   endproperty
   a_emit: assert property (p_emit) else $error("pixel not emitted at count"); // R4

   property p_order;
      cap_valid_reg |-> cap_max_reg >= cap_min_reg;
   endproperty
   a_order: assert property (p_order) else $error("max below min"); // R7

   property p_max_run;
      take && state_reg == PDB_S_RUN && !first && !sweep_start |=> max_reg >= $past(sample_level);
   endproperty
   a_max_run: assert property (p_max_run) else $error("max lost a sample"); // R2

   property p_min_run;
      take && state_reg == PDB_S_RUN && !first && !sweep_start |=> min_reg <= $past(sample_level);
   endproperty
   a_min_run: assert property (p_min_run) else $error("min lost a sample"); // R3

   property p_no_gap;
      !sample_ready |-> cap_valid_reg && !fifo_in_ready;
   endproperty
   a_no_gap: assert property (p_no_gap) else $error("input stalled without cause"); // R5

   property p_swing_gate;
      !cfg.swing_fitted |-> ##1 (eff_reg[0] != PDB_SWING && eff_reg[3] != PDB_SWING);
   endproperty
   a_swing_gate: assert property (p_swing_gate) else $error("swing active without option"); // R14

   property p_common;
      short_td ##1 short_td |-> eff_reg[1] == eff_reg[0] && eff_reg[2] == eff_reg[0];
   endproperty
   a_common: assert property (p_common) else $error("traces differ in short sweep"); // R18

   property p_restrict;
      restricted |=> !(sel_reg[1] == PDB_RMS && $past(sel_write[1]) && $past(sel_value) == PDB_RMS
                       && $past(sel_reg[1]) != PDB_RMS);
   endproperty
   a_restrict: assert property (p_restrict) else $error("rms accepted while restricted"); // R19

   property p_auto_peak;
      sel_reg[2] == PDB_AUTO && trace_mode[2] == PDB_MAXH && !short_td |=> eff_reg[2] == PDB_MAXP;
   endproperty
   a_auto_peak: assert property (p_auto_peak) else $error("auto map wrong"); // R17

   c_emit:  cover property (cap_valid_reg && fifo_in_ready);
   c_full:  cover property (!sample_ready && sample_valid);
   c_done:  cover property ($rose(sweep_done));
   c_apeak: cover property (cap_valid_reg && eff_reg[0] == PDB_APEAK);
endmodule // pdb_detector_bank
`default_nettype wire

// ---- tb/pdb_sample_src.sv ----
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Level sample source.
// ****************************************
module pdb_sample_src (
   input  wire logic   clk,
   input  wire logic   slow,
   input  wire logic   sample_ready,
   output logic        sample_valid,
   output logic [15:0] sample_level
);
   logic [15:0] q[$];
   logic        taken;
   task automatic push(input logic [15:0] v);
      q.push_back(v);
   endtask
   initial begin
      sample_valid = 1'b0;
      sample_level = 16'h0;
      taken        = 1'b0;
   end
   always @(posedge clk) begin
      taken <= sample_valid && sample_ready;
   end
   // A sample is held until taken; with no sample the level keeps toggling.
   always @(negedge clk) begin
      if (taken || !sample_valid) begin
         if (q.size() != 0 && (!slow || $urandom_range(1, 0) == 1)) begin
            sample_valid <= 1'b1;
            sample_level <= q.pop_front();
         end else begin
            sample_valid <= 1'b0;
            sample_level <= ~sample_level;
         end
      end
   end
endmodule // pdb_sample_src
`default_nettype wire

// ---- tb/tb_pdb_detector_bank.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_pdb_detector_bank;
   import pdb_pkg::*;
   logic            clk, rst, sweep_start, sample_valid, sample_ready;
   logic            pix_valid, pix_ready, sweep_done, slow;
   logic [15:0]     spp, sample_level;
   logic [3:0]      sel_write;
   pdb_cfg_t        cfg;
   pdb_mode_t [3:0] trace_mode;
   pdb_det_t        sel_value;
   pdb_det_t [3:0]  det_active;
   pdb_frame_t      pix_data;
   pdb_det_t        sel_m[4];
   logic [15:0]     lv[$];
   int              err_count, n_tests, pix_cnt;

   pdb_detector_bank dut (.clk(clk), .rst(rst), .sweep_start(sweep_start), .samples_per_pixel(spp),
      .cfg(cfg), .trace_mode(trace_mode), .sel_write(sel_write), .sel_value(sel_value),
      .det_active(det_active), .sample_valid(sample_valid), .sample_ready(sample_ready),
      .sample_level(sample_level), .pix_valid(pix_valid), .pix_ready(pix_ready),
      .pix_data(pix_data), .sweep_done(sweep_done));
   pdb_sample_src src (.clk(clk), .slow(slow), .sample_ready(sample_ready),
      .sample_valid(sample_valid), .sample_level(sample_level));

   // ****************************************
   // Expectations.
   // ****************************************
   function automatic bit blocked(pdb_det_t d);
      return (d == PDB_SWING && !cfg.swing_fitted) || ((d == PDB_RMS || d == PDB_AVG) && cfg.time_domain &&
         (cfg.sweep_time_us < 32'h1388 || cfg.pretrigger || cfg.gapped));
   endfunction
   function automatic pdb_det_t res(int t);
      pdb_det_t d;
      d = blocked(sel_m[t]) ? PDB_AUTO : sel_m[t];
      if (d == PDB_AUTO) begin
         d = trace_mode[t] == PDB_CLRW ? PDB_APEAK : trace_mode[t] == PDB_AVGM ? PDB_SAMP :
             trace_mode[t] == PDB_MAXH ? PDB_MAXP : PDB_MINP;
      end
      return d;
   endfunction
   function automatic pdb_det_t exp_det(int t);
      return (cfg.time_domain && cfg.sweep_time_us < 32'h1388) ? res(0) : res(t);
   endfunction
   function automatic pdb_pix_t exp_pix(pdb_det_t d, int b);
      logic [31:0] mx, mn, s;
      logic [63:0] sq;
      mx = 32'h0;
      mn = 32'hffff;
      s  = 32'h0;
      sq = 64'h0;
      for (int k = 0; k < spp; k++) begin
         mx = lv[b+k] > mx ? {16'h0, lv[b+k]} : mx;
         mn = lv[b+k] < mn ? {16'h0, lv[b+k]} : mn;
         s  = s + lv[b+k];
         sq = sq + lv[b+k] * lv[b+k];
      end
      case (d)
         PDB_APEAK: return '{mx, mn};
         PDB_MAXP:  return '{mx, mx};
         PDB_MINP:  return '{mn, mn};
         PDB_SAMP:  return '{{16'h0, lv[b]}, {16'h0, lv[b]}};
         PDB_RMS:   return '{32'(sq / spp), 32'(sq / spp)};
         PDB_AVG:   return '{s / spp, s / spp};
         default:   return '{mx - mn, mx - mn};
      endcase
   endfunction

   // ****************************************
   // Compare and report.
   // ****************************************
   task automatic chk_det(string nm, pdb_det_t e, pdb_det_t g);
      n_tests++;
      if (g !== e) begin
         err_count++;
         $display("Error %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   task automatic chk_pix(string nm, pdb_pix_t e, pdb_pix_t g);
      n_tests++;
      if (g !== e) begin
         err_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_bit(string nm, logic e, logic g);
      n_tests++;
      if (g !== e) begin
         err_count++;
         $display("Error %s expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic close_out;
      if (err_count == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // ****************************************
   // Drivers.
   // ****************************************
   task automatic tick(int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic sel(int t, pdb_det_t v);
      sel_write[t] = 1'b1;
      sel_value    = v;
      if (!blocked(v)) sel_m[t] = v;
      tick(1);
      sel_write = 4'h0;
      tick(2);
   endtask
   task automatic sweep(int n, logic [11:0] d);
      int w;
      for (int t = 0; t < 4; t++) sel(t, pdb_det_t'(d[3*t +: 3]));
      spp = n[15:0];
      lv.delete();
      pix_cnt     = 0;
      pix_ready   = 1'b0;
      sweep_start = 1'b1;
      tick(1);
      sweep_start = 1'b0;
      for (int i = 0; i < 501 * n; i++) begin
         lv.push_back(i < n ? 16'hffff : i < 2 * n ? 16'h0 : 16'($urandom));
         src.push(lv[i]);
      end
      tick(40);
      chk_bit("sample_ready", 1'b0, sample_ready);
      w = 0;
      while (!sweep_done && w < 30000) begin
         pix_ready = $urandom_range(3, 0) != 0;
         tick(1);
         w++;
      end
      pix_ready = 1'b1;
      if (w == 30000) begin
         err_count++;
         close_out();
      end
      tick(30);
      chk_bit("pixel count", 1'b1, pix_cnt == 500);
      chk_bit("sweep_done", 1'b1, sweep_done);
   endtask

   always @(posedge clk) begin
      if (!rst && pix_valid && pix_ready) begin
         chk_bit("index", 1'b1, pix_data.index === pix_cnt[8:0]);
         for (int t = 0; t < 4; t++) chk_pix("pixel", exp_pix(det_active[t], pix_cnt * spp), pix_data.trace[t]);
         pix_cnt++;
      end
   end

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      rst         = 1'b1;
      sweep_start = 1'b0;
      spp         = 16'h1;
      cfg         = '0;
      trace_mode[0] = PDB_CLRW;
      trace_mode[1] = PDB_AVGM;
      trace_mode[2] = PDB_MAXH;
      trace_mode[3] = PDB_MINH;
      sel_write   = 4'h0;
      sel_value   = PDB_AUTO;
      pix_ready   = 1'b1;
      slow        = 1'b0;
      err_count   = 0;
      n_tests     = 0;
      pix_cnt     = 0;
      for (int t = 0; t < 4; t++) sel_m[t] = PDB_AUTO;
      void'($urandom(32813));
      tick(2);
      rst = 1'b0;
      tick(2);
      for (int t = 0; t < 4; t++) chk_det("det_active", exp_det(t), det_active[t]);
      repeat (80) begin
         cfg = pdb_cfg_t'({5'($urandom), $urandom_range(1, 0) ? 32'h1387 : 32'h1388});
         for (int t = 0; t < 4; t++) trace_mode[t] = pdb_mode_t'(2'($urandom));
         sel($urandom_range(3, 0), pdb_det_t'(3'($urandom_range(7, 0))));
         for (int t = 0; t < 4; t++) chk_det("det_active", exp_det(t), det_active[t]);
      end
      cfg = '0;
      cfg.swing_fitted = 1'b1;
      sweep(2, {PDB_SAMP, PDB_APEAK, PDB_MINP, PDB_MAXP});
      slow = 1'b1;
      sweep(3, {PDB_MAXP, PDB_SWING, PDB_AVG, PDB_RMS});
      close_out();
   end
endmodule // tb_pdb_detector_bank
`default_nettype wire
